// >>> rtl/swn_pkg.sv
package swn_pkg;
   // Array organisation
   localparam int WORDS       = 100;   // Addressable words
   localparam int WORD_W      = 14;    // Bits per word
   localparam int DIGITS      = 10;    // Positions in one digit code
   localparam int ADDR_W      = 7;     // Binary word index width
   localparam int ACODE_W     = 2 * DIGITS; // Two digit codes back to back

   // Timing
   localparam int CLK_MHZ     = 100;   // System clock rate
   localparam int T_PROG_MS   = 20;    // Erase or write time per word
   localparam int PROG_CYC    = T_PROG_MS * 1000 * CLK_MHZ; // Cycles of one programming pass

   // Reset values and erased content
   localparam logic [WORD_W-1:0]  DATA_RST  = 14'h0000;
   localparam logic [ACODE_W-1:0] ACODE_RST = 20'h00000;
   localparam logic [WORD_W-1:0]  ERASED    = 14'h0000; // Content of an erased word

   // Operation codes on the three mode lines {c,b,a}
   typedef enum logic [2:0] {
      MODE_IDLE  = 3'h0,
      MODE_READ  = 3'h1,
      MODE_ERASE = 3'h2,
      MODE_ADDR  = 3'h3,
      MODE_WRITE = 3'h4,
      MODE_SHOUT = 3'h5,
      MODE_DATA  = 3'h6,
      MODE_RSVD  = 3'h7
   } swn_mode_t;

   // Programming job handed from the pin side to the array engine
   typedef struct packed {
      logic              wr;    // 1 = write, 0 = erase
      logic [ADDR_W-1:0] addr;  // Word index
      logic [WORD_W-1:0] data;  // Bits to set on a write
   } swn_job_t;

   // Programming engine states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_PROG = 2'b10
   } swn_state_t;
endpackage : swn_pkg

// >>> rtl/swn_strm_if.sv
`timescale 1ns/1ns
// Valid/ready stream between the pin side and the array engine
interface swn_strm_if #(parameter int W = 8);
   logic         valid; // Word offered
   logic         ready; // Word can be taken
   logic [W-1:0] data;  // Word itself
   modport tx (output valid, output data, input ready);
   modport rx (input valid, input data, output ready);
endinterface : swn_strm_if

// >>> rtl/swn_buf2.sv
`timescale 1ns/1ns
// Small FIFO; DEPTH must be a power of two so the pointers wrap by themselves
module swn_buf2 #(
   parameter int W     = 22,
   parameter int DEPTH = 2
) (
   input  wire logic sys_clk_in,
   input  wire logic rst_n_in,
   swn_strm_if.rx    fill_in,
   swn_strm_if.tx    drain_out
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);

   logic [W-1:0] slot_r [DEPTH]; // Storage entries
   logic [PW-1:0] wr_ptr_r;      // Next slot to fill
   logic [PW-1:0] rd_ptr_r;      // Oldest slot
   logic [PW:0]   count_r;       // Entries held
   logic          push;
   logic          pop;

   // Honest flags: full stalls the source, empty hides stale data
   assign fill_in.ready   = (count_r != FULL_CNT);
   assign drain_out.valid = (count_r != '0);
   assign drain_out.data  = slot_r[rd_ptr_r];
   assign push            = fill_in.valid & fill_in.ready;
   assign pop             = drain_out.valid & drain_out.ready;

   // Storage needs no reset; count decides what is valid
   always_ff @(posedge sys_clk_in) begin
      if (push) begin
         slot_r[wr_ptr_r] <= fill_in.data;
      end
   end

   // Pointers and occupancy
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
         if (push && !pop) begin
            count_r <= count_r + 1'b1;
         end else if (pop && !push) begin
            count_r <= count_r - 1'b1;
         end
      end
   end
endmodule : swn_buf2

// >>> rtl/swn_nvm_port.sv
`timescale 1ns/1ns
// Operation
// R1 - 100 words of 14 bits, each altered alone
// R2 - One shared data pin, driven only outputting
// R3 - Address is two one-hot ten-position digit codes
// R4 - Three mode lines select the operation
// R5 - Address, read, shift out, erase, data, write
// R6 - First bit at mode change, then rising edges
// R7 - Read loads whole word into data register
// R8 - Controller waits twenty milliseconds per program
// R9 - Controller holds mode, erases before writing
module swn_nvm_port
   import swn_pkg::*;
#(
   parameter int PROG_CYCLES = PROG_CYC
) (
   input  wire logic sys_clk_in,
   input  wire logic rst_n_in,
   input  wire logic mode_line_a_in,
   input  wire logic mode_line_b_in,
   input  wire logic mode_line_c_in,
   input  wire logic link_clk_in,
   input  wire logic data_in,
   output logic      data_out,
   output logic      data_oe_out,
   output logic      busy_out
);
   localparam int CW = $clog2(PROG_CYCLES + 1);
   localparam logic [CW-1:0] CNT_LOAD = CW'(PROG_CYCLES - 1);

   logic [WORD_W-1:0]  array_r [WORDS];  // The word store itself, R1
   swn_mode_t          mode;             // Decoded mode lines
   swn_mode_t          mode_r;           // Mode seen last cycle
   logic               mode_entry;       // Mode changed this cycle
   logic               lclk_r;           // Link clock last cycle
   logic               lclk_rise;        // Rising edge of link clock
   logic [ACODE_W-1:0] acode_r;          // Shifted address codes
   logic [WORD_W-1:0]  dreg_r;           // Data register
   logic [3:0]         tens;             // First digit as a number
   logic [3:0]         units;            // Second digit as a number
   logic               tens_ok;          // First code is one-hot
   logic               units_ok;         // Second code is one-hot
   logic [ADDR_W-1:0]  addr;             // Selected word index
   logic               addr_ok;          // Address code legal
   logic               pend_r;           // Job waiting for the buffer
   swn_job_t           pend_job_r;       // That job
   swn_job_t           job_r;            // Job being programmed
   swn_state_t         state_r;          // Engine state
   logic [CW-1:0]      cnt_r;            // Programming time left
   logic               commit;           // Last cycle of programming

   swn_strm_if #(.W($bits(swn_job_t))) fill_s ();
   swn_strm_if #(.W($bits(swn_job_t))) drain_s ();

   // One-hot digit to number; anything else is refused
   function automatic logic [4:0] digit_dec(input logic [DIGITS-1:0] code);
      logic [4:0] res;
      res = 5'h00;
      for (int i = 0; i < DIGITS; i++) begin
         if (code == (DIGITS'(1) << i)) begin
            res = {1'b1, 4'(i)};
         end
      end
      return res;
   endfunction : digit_dec

   assign mode       = swn_mode_t'({mode_line_c_in, mode_line_b_in, mode_line_a_in}); // R4
   assign mode_entry = (mode != mode_r);
   assign lclk_rise  = link_clk_in & ~lclk_r;

   // Address from two digit codes, first code is the tens digit
   assign {tens_ok, tens}   = digit_dec(acode_r[ACODE_W-1:DIGITS]);  // R3
   assign {units_ok, units} = digit_dec(acode_r[DIGITS-1:0]);        // R3
   // Widen before the product: tens times ten needs seven bits, not four
   assign addr    = ADDR_W'(tens) * ADDR_W'(DIGITS) + ADDR_W'(units); // R3
   assign addr_ok = tens_ok & units_ok;

   // Mode and link clock history; pins are already synchronous
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mode_r <= MODE_IDLE;
         lclk_r <= 1'b0;
      end else begin
         mode_r <= mode;
         lclk_r <= link_clk_in;
      end
   end

   // Address code shifts in on link clock rising edges
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         acode_r <= ACODE_RST;
      end else if (mode == MODE_ADDR && lclk_rise) begin
         acode_r <= {acode_r[ACODE_W-2:0], data_in}; // R2 R5
      end
   end

   // Data register: read load, serial load and serial unload
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         dreg_r <= DATA_RST;
      end else begin
         unique case (mode)
            MODE_READ: begin
               // Load once per read, so a held mode does not refetch
               if (mode_entry && addr_ok) begin
                  dreg_r <= array_r[addr]; // R7 R5
               end
            end
            MODE_DATA: begin
               if (lclk_rise) begin
                  dreg_r <= {dreg_r[WORD_W-2:0], data_in}; // R5
               end
            end
            MODE_SHOUT: begin
               if (lclk_rise && !mode_entry) begin
                  dreg_r <= {dreg_r[WORD_W-2:0], 1'b0}; // R6
               end
            end
            default: begin
               dreg_r <= dreg_r;
            end
         endcase
      end
   end

   // Pin drive: only shift out owns the wire, MSB first
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         data_out    <= 1'b0;
         data_oe_out <= 1'b0;
      end else if (mode == MODE_SHOUT) begin
         data_oe_out <= 1'b1; // R2
         if (mode_entry) begin
            data_out <= dreg_r[WORD_W-1]; // R6
         end else if (lclk_rise) begin
            data_out <= dreg_r[WORD_W-2]; // R6
         end
      end else begin
         data_oe_out <= 1'b0; // R2
         data_out    <= 1'b0;
      end
   end

   // Erase or write request waits here while the buffer is full
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pend_r     <= 1'b0;
         pend_job_r <= '0;
      end else if (mode_entry && addr_ok && (mode == MODE_ERASE || mode == MODE_WRITE)) begin
         // New request wins over the handover of an older one
         pend_r          <= 1'b1; // R5
         pend_job_r.wr   <= (mode == MODE_WRITE);
         pend_job_r.addr <= addr;
         pend_job_r.data <= dreg_r;
      end else if (fill_s.ready) begin
         pend_r <= 1'b0;
      end
   end

   assign fill_s.valid = pend_r;
   assign fill_s.data  = pend_job_r;

   // Two entries absorb a write issued during an erase
   swn_buf2 #(
      .W     ($bits(swn_job_t)),
      .DEPTH (2)
   ) u_buf (
      .sys_clk_in (sys_clk_in),
      .rst_n_in   (rst_n_in),
      .fill_in    (fill_s),
      .drain_out  (drain_s)
   );

   // Engine stalls the buffer for the whole programming time
   assign drain_s.ready = (state_r == ST_IDLE);
   assign commit        = (state_r == ST_PROG) && (cnt_r == '0);

   // Programming engine
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_r <= ST_IDLE;
         cnt_r   <= '0;
         job_r   <= '0;
      end else begin
         unique case (state_r)
            ST_IDLE: begin
               if (drain_s.valid) begin
                  job_r   <= drain_s.data;
                  cnt_r   <= CNT_LOAD;
                  state_r <= ST_PROG;
               end
            end
            ST_PROG: begin
               if (cnt_r == '0) begin
                  state_r <= ST_IDLE;
               end else begin
                  cnt_r <= cnt_r - 1'b1;
               end
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // Array update; only the selected word changes. Writes only set
   // bits, so an unerased word ends up as the OR of old and new.
   // No reset: the store keeps its content across a reset.
   always_ff @(posedge sys_clk_in) begin
      if (commit) begin
         if (job_r.wr) begin
            array_r[job_r.addr] <= array_r[job_r.addr] | job_r.data; // R1 R9
         end else begin
            array_r[job_r.addr] <= ERASED; // R1
         end
      end
   end

   // Busy while any alteration is queued or running
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         busy_out <= 1'b0;
      end else begin
         busy_out <= pend_r | drain_s.valid | (state_r != ST_IDLE) | commit; // R8
      end
   end
endmodule : swn_nvm_port

// >>> testbench/swn_nvm_port_props.sv
`timescale 1ns/1ns
// Pin-side timing of the word store port
module swn_nvm_port_props
   import swn_pkg::*;
#(
   parameter int PROG_CYCLES = 20
) (
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   input wire logic mode_line_a_in,
   input wire logic mode_line_b_in,
   input wire logic mode_line_c_in,
   input wire logic link_clk_in,
   input wire logic data_in,
   input wire logic data_out,
   input wire logic data_oe_out,
   input wire logic busy_out
);
   logic [2:0]  mode;   // Code {c,b,a}
   logic        link_r; // Link level one sample ago
   logic [2:0]  rise_r; // Recent link rises
   logic [31:0] busy_r; // Cycles busy so far
   assign mode = {mode_line_c_in, mode_line_b_in, mode_line_a_in};
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);
   // Rise history, so a bit change can be traced to its link edge
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         link_r <= 1'b0;
         rise_r <= 3'h0;
      end else begin
         link_r <= link_clk_in;
         rise_r <= {rise_r[1:0], link_clk_in & ~link_r};
      end
   end
   // Busy stretch length
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) busy_r <= 32'h0;
      else busy_r <= busy_out ? busy_r + 32'h1 : 32'h0;
   end
   a_pin_owner: assert property (data_oe_out |-> $past(mode) == MODE_SHOUT || $past(mode, 2) == MODE_SHOUT)
      else $error("pin driven outside shift out");
   a_quiet_low: assert property (!data_oe_out |-> !data_out)
      else $error("data out not low while released");
   a_shout_start: assert property (mode == MODE_SHOUT && $past(mode) != MODE_SHOUT |-> ##[1:2] data_oe_out)
      else $error("shift out did not take the pin");
   a_shout_stop: assert property ((mode != MODE_SHOUT) [*2] |=> !data_oe_out)
      else $error("pin held after leaving shift out");
   a_bit_hold: assert property (data_oe_out && $past(data_oe_out) && rise_r == 3'h0 |-> $stable(data_out))
      else $error("data bit moved without a link rise");
   a_busy_cause: assert property ($rose(busy_out) |-> mode inside {MODE_ERASE, MODE_WRITE} && $past(mode, 2) == mode)
      else $error("busy without erase or write");
   a_busy_min: assert property ($rose(busy_out) |-> busy_out [*8])
      else $error("programming pass too short");
   a_busy_max: assert property (busy_r <= 2 * PROG_CYCLES + 8)
      else $error("programming pass too long");
endmodule : swn_nvm_port_props

bind swn_nvm_port swn_nvm_port_props #(.PROG_CYCLES(PROG_CYCLES)) i_swn_nvm_port_props (
   .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .mode_line_a_in(mode_line_a_in),
   .mode_line_b_in(mode_line_b_in), .mode_line_c_in(mode_line_c_in), .link_clk_in(link_clk_in),
   .data_in(data_in), .data_out(data_out), .data_oe_out(data_oe_out), .busy_out(busy_out));

// >>> testbench/swn_ctrl_model.sv
`timescale 1ns/1ns
// Controller at the far side: mode lines, serial clock and its half of the pin
module swn_ctrl_model
   import swn_pkg::*;
(
   input  wire logic  sys_clk_in,
   input  wire logic  pin_in,   // Resolved pin level
   output logic [2:0] mode_out, // Code {c,b,a}
   output logic       link_out, // Still outside frames; pulsed through programming passes
   output logic       drv_out,  // Controller drives the pin
   output logic       bit_out   // Value it drives
);
   initial begin
      mode_out = MODE_IDLE;
      link_out = 1'b0;
      drv_out = 1'b0;
      bit_out = 1'b0;
   end
   // Moves just after the edge, so the port never races the sample
   task tick(input int n);
      repeat (n) @(posedge sys_clk_in);
      #1;
   endtask : tick
   // One link pulse; the clock keeps running through programming
   task spin;
      link_out = 1'b1;
      tick(1);
      link_out = 1'b0;
      tick(1);
   endtask : spin
   task go(input swn_mode_t m, input int n);
      mode_out = m;
      tick(n);
   endtask : go
   // Serial bits, MSB first; data set up two cycles before each rise
   task send(input swn_mode_t m, input logic [19:0] v, input int n);
      go(m, 2);
      drv_out = 1'b1;
      for (int i = n - 1; i >= 0; i--) begin
         bit_out = v[i];
         tick(2);
         link_out = 1'b1;
         tick(2);
         link_out = 1'b0;
      end
      drv_out = 1'b0;
      go(MODE_IDLE, 2);
   endtask : send
   // Tens code first, one-hot over ten positions each
   task addr(input int w);
      send(MODE_ADDR, {10'h001 << (w / 10), 10'h001 << (w % 10)}, 20);
   endtask : addr
   // Word plus one trailing bit, first bit taken before any rise
   task get(output logic [14:0] v);
      go(MODE_SHOUT, 3);
      for (int i = 14; i >= 0; i--) begin
         v[i] = pin_in;
         link_out = 1'b1;
         tick(3);
         link_out = 1'b0;
         tick(1);
      end
      go(MODE_IDLE, 3);
   endtask : get
endmodule : swn_ctrl_model

// >>> testbench/swn_nvm_port_bench.sv
`timescale 1ns/1ns
// Drives the port through the controller model and judges the pins
module swn_nvm_port_bench
   import swn_pkg::*;
;
   localparam int PROG = 40; // Short pass keeps the run brief
   logic        clk;         // System clock
   logic        rst_n;       // Reset, active low
   logic [2:0]  mode;        // Code {c,b,a}
   logic        link;        // Serial clock
   logic        drv;         // Controller drives the pin
   logic        dbit;        // Its value
   logic        float_r;     // Undriven pin pattern
   logic        pin;         // Resolved pin
   logic        dout;        // Device pin value
   logic        oe;          // Device drives the pin
   logic        busy;        // Programming
   logic [14:0] got;         // Bits shifted out
   int          fail_count;  // Mismatches
   int          checks_done; // Compares
   // Nobody drives: the level changes every cycle, so no stale bit passes
   assign pin = oe ? dout : drv ? dbit : float_r;
   always #5 clk = ~clk;
   always @(posedge clk) float_r <= ~float_r;
   swn_nvm_port #(.PROG_CYCLES(PROG)) i_swn_nvm_port (.sys_clk_in(clk), .rst_n_in(rst_n),
      .mode_line_a_in(mode[0]), .mode_line_b_in(mode[1]), .mode_line_c_in(mode[2]), .link_clk_in(link),
      .data_in(pin), .data_out(dout), .data_oe_out(oe), .busy_out(busy));
   swn_ctrl_model i_swn_ctrl_model (.sys_clk_in(clk), .pin_in(pin), .mode_out(mode), .link_out(link),
      .drv_out(drv), .bit_out(dbit));
   task chk(input string what, input logic [14:0] exp, input logic [14:0] seen);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task results;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : results
   // Holds the code and runs the link until busy falls; a hang counts as a mismatch
   task prog(input swn_mode_t m);
      int n;
      i_swn_ctrl_model.go(m, 4);
      chk("busy", 15'h1, {14'h0, busy});
      n = 0;
      while (busy !== 1'b0 && n < 4 * PROG) begin
         i_swn_ctrl_model.spin();
         n++;
      end
      if (n >= 4 * PROG) begin
         fail_count++;
         results();
      end
      i_swn_ctrl_model.go(MODE_IDLE, 4);
   endtask : prog
   // Read word w; the bit after the word must be zero
   task rd(input int w, input logic [13:0] d);
      i_swn_ctrl_model.addr(w);
      i_swn_ctrl_model.go(MODE_READ, 3);
      i_swn_ctrl_model.get(got);
      chk("word", {d, 1'b0}, got);
   endtask : rd
   task t_store(input int w, input logic [13:0] d);
      i_swn_ctrl_model.addr(w);
      i_swn_ctrl_model.send(MODE_DATA, {6'h0, d}, 14);
      prog(MODE_ERASE);
      prog(MODE_WRITE);
      rd(w, d);
   endtask : t_store
   // Write without erase: new bits join the old ones
   task t_merge(input int w, input logic [13:0] d, input logic [13:0] exp);
      i_swn_ctrl_model.addr(w);
      i_swn_ctrl_model.send(MODE_DATA, {6'h0, d}, 14);
      prog(MODE_WRITE);
      rd(w, exp);
   endtask : t_merge
   // Erase alone leaves the word at its erased content
   task t_erase(input int w);
      i_swn_ctrl_model.addr(w);
      prog(MODE_ERASE);
      rd(w, ERASED);
   endtask : t_erase
   // Two-hot digits: every code but shift out must leave pin and busy alone
   task t_refuse;
      i_swn_ctrl_model.send(MODE_ADDR, 20'h00c03, 20);
      for (int m = 0; m < 8; m++) begin
         if (m != 5) begin
            i_swn_ctrl_model.go(swn_mode_t'(m), 6);
            chk("oe busy", 15'h0, {13'h0, oe, busy});
         end
      end
      i_swn_ctrl_model.go(MODE_IDLE, 2);
   endtask : t_refuse
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      float_r = 1'b0;
      fail_count = 0;
      checks_done = 0;
      repeat (16) @(posedge clk);
      #1 rst_n = 1'b1;
      chk("idle pins", 15'h0, {12'h0, oe, dout, busy});
      t_store(0, 14'h1234);
      t_store(99, 14'h3fff);
      rd(0, 14'h1234);
      t_store(57, 14'h0f0f);
      t_merge(57, 14'h3000, 14'h3f0f);
      t_erase(99);
      rd(0, 14'h1234);
      t_refuse();
      results();
   end
endmodule : swn_nvm_port_bench
